// ---- bench/amd_cpu_map_chk.sv ----
`timescale 1ns/1ps
module amd_cpu_map_chk
(
	input wire logic        sys_clk,              // Clock
	input wire logic        rst_n,                // Reset, active low
	input wire logic [15:0] cpu_addr,             // Address
	input wire logic        cpu_rd,               // Read strobe
	input wire logic        cpu_wr,               // Write strobe
	input wire logic [7:0]  cpu_rdata,            // Read data
	input wire logic        code_ram_load_enable, // Load bit
	input wire logic        coproc_in_reset,      // Coprocessor held
	input wire logic        load_active,          // Code RAM routed
	input wire logic        device_reset_req,     // Reset pulse
	input wire logic        stack_hit,            // Stack area
	input wire logic        dram_sel,             // Data RAM
	input wire logic        code_sel,             // Code RAM
	input wire logic        shared_dual_port_ram_sel,            // Dual-port RAM
	input wire logic        rom_sel,              // ROM
	input wire logic        periph_sel,           // Peripherals
	input wire logic [15:0] mem_addr              // Local address
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	logic acc;
	assign acc = cpu_rd || cpu_wr;
	rsvd_reset_a: assert property (acc && cpu_addr inside {[16'h001a:16'h001f]}
		|=> device_reset_req)
		else $error("reserved access gave no reset");
	reset_cause_a: assert property (device_reset_req
		|-> $past(acc && cpu_addr inside {[16'h001a:16'h001f]}))
		else $error("reset pulse without cause");
	hole_zero_a: assert property (cpu_rd && cpu_addr == 16'h0002 |=> cpu_rdata == 8'h00)
		else $error("hole read not zero");
	stack_area_a: assert property (acc
		|-> stack_hit == (cpu_addr inside {[16'h0100:16'h01ff]}))
		else $error("stack flag wrong");
	page_shared_dual_port_ram_a: assert property (acc && cpu_addr inside {[16'h1100:16'h24ff]}
		&& !load_active |-> shared_dual_port_ram_sel && !code_sel && mem_addr == cpu_addr - 16'h1100)
		else $error("window not on dual-port RAM");
	page_code_a: assert property (acc && cpu_addr inside {[16'h1100:16'h18ff]}
		&& load_active |-> code_sel && !shared_dual_port_ram_sel)
		else $error("window not on code RAM");
	code_block_a: assert property (!load_active |-> !code_sel)
		else $error("code RAM reached while not loading");
	load_gate_a: assert property ($rose(load_active)
		|-> $past(code_ram_load_enable && coproc_in_reset))
		else $error("load set outside coprocessor reset");
	load_clear_a: assert property (!code_ram_load_enable |=> !load_active)
		else $error("load not cleared");
	rom_write_a: assert property (cpu_wr |-> !rom_sel)
		else $error("ROM selected on write");
	one_select_a: assert property ($onehot0({dram_sel, code_sel, shared_dual_port_ram_sel, rom_sel, periph_sel}))
		else $error("several selects at once");
endmodule // amd_cpu_map_chk

// ---- bench/amd_cpu_model.sv ----
`timescale 1ns/1ps
module amd_cpu_model
(
	input  wire logic        sys_clk,   // Bus clock
	output logic      [15:0] cpu_addr,  // Address out
	output logic             cpu_rd,    // Read strobe
	output logic             cpu_wr,    // Write strobe
	output logic      [7:0]  cpu_wdata, // Write data
	input  wire logic [7:0]  cpu_rdata  // Read data in
);
	initial
	begin
		cpu_addr = 16'h0000;
		cpu_rd = 1'b0;
		cpu_wr = 1'b0;
		cpu_wdata = 8'h00;
	end
	task automatic start(input logic wr, input logic [15:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		cpu_addr = a;
		cpu_rd = !wr;
		cpu_wr = wr;
		cpu_wdata = d;
	endtask
	// Released lines inverted so stale values never decode
	task automatic finish(output logic [7:0] q);
		@(negedge sys_clk);
		q = cpu_rdata;
		cpu_rd = 1'b0;
		cpu_wr = 1'b0;
		cpu_addr = ~cpu_addr;
		cpu_wdata = ~cpu_wdata;
	endtask
endmodule // amd_cpu_model

// ---- bench/tb_amd_cpu_map.sv ----
`timescale 1ns/1ps
module tb_amd_cpu_map;
	import amd_pkg::*;
	logic        sys_clk = 1'b0;
	logic        rst_n, cpu_rd, cpu_wr, vec_remap, code_ram_load_enable, coproc_in_reset;
	logic        load_active, device_reset_req, stack_hit, sh, ld, rm, mem_wr;
	logic        dram_sel, code_sel, shared_dual_port_ram_sel, rom_sel, periph_sel;
	logic [15:0] cpu_addr, mem_addr, frame_number, out_byte_count, ma, eo;
	logic [7:0]  cpu_wdata, cpu_rdata, dram_rdata, code_rdata, shared_dual_port_ram_rdata, rom_rdata;
	logic [7:0]  periph_rdata, ep0_fifo_rdata, ep1_fifo_rdata, ep2_fifo_rdata, v, e;
	logic [7:0]  in_endpoint_interrupt_flags, out_endpoint_interrupt_flags;
	logic [7:0]  bus_event_interrupt_flags, in_interrupt_enables;
	logic [7:0]  mem_wdata, fwd, ro [12], wv [64];
	logic [4:0]  s, es;
	logic [2:0]  frd, fwr;
	logic [8:0]  mw;
	logic [127:0] rnd;
	int          seed, n_errors, n_compared, cycles, k;
	logic [15:0] rw_tab [21] = '{16'h0020, 16'h0100, 16'h0707, 16'h0906, 16'h0a06, 16'h0e00,
		16'h0f00, 16'h1000, 16'h1100, 16'h1200, 16'h1300, 16'h1400, 16'h1500, 16'h1600,
		16'h1700, 16'h2600, 16'h2700, 16'h2800, 16'h2900, 16'h2a00, 16'h2b00};
	logic [5:0]  oa [12] = '{6'h00, 6'h01, 6'h09, 6'h0a, 6'h0e, 6'h0f, 6'h26, 6'h27,
		6'h28, 6'h29, 6'h2a, 6'h2b};
	logic [7:0]  holes [7] = '{8'h02, 8'h04, 8'h06, 8'h08, 8'h20, 8'h22, 8'h24};
	logic [7:0]  srcs [10] = '{8'h03, 8'h05, 8'h0b, 8'h0c, 8'h0d, 8'h18, 8'h19, 8'h21, 8'h23, 8'h25};
	logic [15:0] edges [18] = '{16'h002c, 16'h007f, 16'h0080, 16'h0100, 16'h01ff, 16'h107f,
		16'h1080, 16'h10ff,
		16'h1100, 16'h18ff, 16'h1900, 16'h24ff, 16'h2500, 16'h27ff, 16'h2800, 16'hffdf,
		16'hffe0, 16'hffff};

	amd_cpu_model amd_cpu_model_inst (.sys_clk, .cpu_addr, .cpu_rd, .cpu_wr, .cpu_wdata, .cpu_rdata);
	amd_cpu_map amd_cpu_map_inst (.sys_clk, .rst_n, .cpu_addr, .cpu_rd, .cpu_wr, .cpu_wdata,
		.cpu_rdata, .vec_remap, .code_ram_load_enable, .coproc_in_reset, .load_active,
		.device_reset_req, .stack_hit, .dram_sel, .code_sel, .shared_dual_port_ram_sel, .rom_sel, .periph_sel,
		.mem_wr, .mem_addr, .mem_wdata, .dram_rdata, .code_rdata, .shared_dual_port_ram_rdata, .rom_rdata,
		.periph_rdata, .in_endpoint_interrupt_flags, .out_endpoint_interrupt_flags,
		.bus_event_interrupt_flags, .frame_number, .out_byte_count, .fifo_rd(frd),
		.fifo_wr(fwr), .fifo_wdata(fwd), .ep0_fifo_rdata, .ep1_fifo_rdata, .ep2_fifo_rdata,
		.power_management(ro[0]), .function_address(ro[1]), .in_interrupt_enables,
		.out_interrupt_enables(ro[2]), .bus_event_interrupt_enables(ro[3]),
		.test_modes(ro[4]), .endpoint_index(ro[5]), .port_a_out(ro[6]), .port_a_dir(ro[7]),
		.port_a_opt(ro[8]), .port_b_out(ro[9]), .port_b_dir(ro[10]), .port_b_opt(ro[11]));

	always #25 sys_clk = ~sys_clk;

	task automatic close_out;
		$display("compared %0d, mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	always @(posedge sys_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 5000)
		begin
			n_errors++;
			close_out();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_compared++;
		if (got !== exp)
		begin
			n_errors++;
			$display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// Selects sampled mid-cycle, data after the answer edge
	task automatic acc(input logic wr, input logic [15:0] a, input logic [7:0] d);
		amd_cpu_model_inst.start(wr, a, d);
		#5;
		s = {dram_sel, code_sel, shared_dual_port_ram_sel, rom_sel, periph_sel};
		ma = mem_addr;
		sh = stack_hit;
		mw = {mem_wr, mem_wdata};
		amd_cpu_model_inst.finish(v);
	endtask

	function automatic logic [2:0] fifo_hit(input logic [7:0] a);
		return {a == 8'h25, a == 8'h23, a == 8'h21};
	endfunction

	function automatic logic [7:0] src_val(input logic [7:0] a);
		case (a)
			8'h03: return in_endpoint_interrupt_flags;
			8'h05: return out_endpoint_interrupt_flags;
			8'h0b: return bus_event_interrupt_flags;
			8'h0c: return frame_number[15:8];
			8'h0d: return frame_number[7:0];
			8'h18: return out_byte_count[15:8];
			8'h19: return out_byte_count[7:0];
			8'h21: return ep0_fifo_rdata;
			8'h23: return ep1_fifo_rdata;
			default: return ep2_fifo_rdata;
		endcase
	endfunction

	function automatic void exp_map(input logic [15:0] a);
		{es, eo, e} = '0;
		if (rm && a >= 16'hffe0)
			{es, eo, e} = {5'h10, 16'h0fe0 + a[4:0], dram_rdata};
		else if (a >= 16'h2800)
			{es, eo, e} = {5'h02, a - 16'h2800, rom_rdata};
		else if (a >= 16'h1100 && a <= 16'h24ff)
		begin
			if (!ld)
				{es, eo, e} = {5'h04, a - 16'h1100, shared_dual_port_ram_rdata};
			else if (a <= 16'h18ff)
				{es, eo, e} = {5'h08, a - 16'h1100, code_rdata};
		end
		else if (a >= 16'h0080 && a <= 16'h107f)
			{es, eo, e} = {5'h10, a - 16'h0080, dram_rdata};
		else if (a >= 16'h002c && a <= 16'h007f)
			{es, eo, e} = {5'h01, a, periph_rdata};
	endfunction

	task automatic sweep(input logic [15:0] a);
		exp_map(a);
		acc(1'b0, a, 8'h00);
		chk(s, es, "select");
		if (es != 5'h00)
			chk(ma, eo, "local address");
		chk(v, e, "memory data");
		chk(sh, a >= 16'h0100 && a <= 16'h01ff, "stack flag");
	endtask

	initial
	begin
		seed = 63855;
		rst_n = 1'b0;
		vec_remap = 1'b0;
		code_ram_load_enable = 1'b0;
		coproc_in_reset = 1'b0;
		rnd = {$random(seed), $random(seed), $random(seed), $random(seed)};
		{dram_rdata, code_rdata, shared_dual_port_ram_rdata, rom_rdata, periph_rdata, in_endpoint_interrupt_flags,
			out_endpoint_interrupt_flags, bus_event_interrupt_flags, frame_number, out_byte_count,
			ep0_fifo_rdata, ep1_fifo_rdata, ep2_fifo_rdata} = rnd[119:0];
		repeat (6) @(posedge sys_clk);
		@(negedge sys_clk);
		chk({cpu_rdata, device_reset_req, load_active}, 10'h000, "reset state");
		rst_n = 1'b1;
		chk(in_interrupt_enables, 8'h07, "enables at reset");
		foreach (rw_tab[i])
		begin
			acc(1'b0, {8'h00, rw_tab[i][15:8]}, 8'h00);
			chk(v, rw_tab[i][7:0], "reset value");
		end
		$display("test reset_values done");
		foreach (rw_tab[i])
		begin
			e = 8'($random(seed));
			wv[rw_tab[i][13:8]] = e;
			acc(1'b1, {8'h00, rw_tab[i][15:8]}, e);
			acc(1'b0, {8'h00, rw_tab[i][15:8]}, 8'h00);
			chk(v, e, "read back");
		end
		foreach (ro[j])
			chk(ro[j], wv[oa[j]], "register output");
		foreach (holes[i])
		begin
			acc(1'b1, {8'h00, holes[i]}, 8'hff);
			acc(1'b0, {8'h00, holes[i]}, 8'h00);
			chk(v, 8'h00, "unused reads zero");
		end
		foreach (srcs[i])
		begin
			acc(1'b1, {8'h00, srcs[i]}, ~src_val(srcs[i]));
			chk({fwr, fwd}, {fifo_hit(srcs[i]), ~src_val(srcs[i])}, "fifo write");
			acc(1'b0, {8'h00, srcs[i]}, 8'h00);
			chk(v, src_val(srcs[i]), "status read");
			chk(frd, fifo_hit(srcs[i]), "fifo read");
		end
		$display("test register_access done");
		for (k = 16'h1a; k <= 16'h1f; k++)
		begin
			acc(k[0], 16'(k), 8'h5a);
			chk(device_reset_req, 1'b1, "device reset");
			@(negedge sys_clk);
			chk(device_reset_req, 1'b0, "reset pulse end");
		end
		$display("test reserved done");
		for (k = 0; k < 4; k++)
		begin
			{ld, rm} = 2'(k);
			@(negedge sys_clk);
			vec_remap = rm;
			coproc_in_reset = ld;
			code_ram_load_enable = ld;
			repeat (2) @(negedge sys_clk);
			chk(load_active, ld, "load routing");
			foreach (edges[i])
				sweep(edges[i]);
			repeat (20)
				sweep(16'($random(seed)) | 16'h0080);
		end
		code_ram_load_enable = 1'b0;
		ld = 1'b0;
		repeat (2) @(negedge sys_clk);
		chk(load_active, 1'b0, "load cleared");
		sweep(16'h1100);
		coproc_in_reset = 1'b0;
		code_ram_load_enable = 1'b1;
		repeat (2) @(negedge sys_clk);
		chk(load_active, 1'b0, "load refused");
		sweep(16'h18ff);
		acc(1'b1, 16'h1100, 8'ha5);
		chk({s, ma, mw}, {5'h04, 16'h0000, 9'h1a5}, "window write");
		acc(1'b1, 16'h2800, 8'h3c);
		chk({s, mw[8]}, 6'h00, "ROM write");
		$display("test memory_map done");
		close_out();
	end
endmodule // tb_amd_cpu_map

bind amd_cpu_map amd_cpu_map_chk amd_cpu_map_chk_inst (.sys_clk, .rst_n, .cpu_addr, .cpu_rd,
	.cpu_wr, .cpu_rdata, .code_ram_load_enable, .coproc_in_reset, .load_active,
	.device_reset_req, .stack_hit, .dram_sel, .code_sel, .shared_dual_port_ram_sel, .rom_sel, .periph_sel,
	.mem_addr);

// ---- inc/amd_defines.svh ----
`ifndef AMD_DEFINES_SVH
`define AMD_DEFINES_SVH

`define AMD_REG_LAST      16'h002b
`define AMD_PERIPH_LAST   16'h007f
`define AMD_RSVD_FIRST    6'h1a
`define AMD_RSVD_LAST     6'h1f
`define AMD_DRAM_BASE     16'h0080
`define AMD_DRAM_LAST     16'h107f
`define AMD_STACK_BASE    16'h0100
`define AMD_STACK_LAST    16'h01ff
`define AMD_PAGE_BASE     16'h1100
`define AMD_PAGE_LAST     16'h24ff
`define AMD_CODE_SIZE     16'h0800
`define AMD_ROM_BASE      16'h2800
`define AMD_VEC_BASE      16'hffe0
`define AMD_VEC_RAM_BASE  16'h0fe0

`define AMD_OFS_PWR       6'h00
`define AMD_OFS_FUNCTION_ADDRESS     6'h01
`define AMD_OFS_IN_FLAGS  6'h03
`define AMD_OFS_OUT_FLAGS 6'h05
`define AMD_OFS_IN_IEN    6'h07
`define AMD_OFS_OUT_IEN   6'h09
`define AMD_OFS_BUS_IEN   6'h0a
`define AMD_OFS_BUS_FLAGS 6'h0b
`define AMD_OFS_FRAME_HI  6'h0c
`define AMD_OFS_FRAME_LO  6'h0d
`define AMD_OFS_TEST      6'h0e
`define AMD_OFS_INDEX     6'h0f
`define AMD_OFS_IN_MAX_H  6'h10
`define AMD_OFS_IN_MAX_L  6'h11
`define AMD_OFS_IN_CSR_H  6'h12
`define AMD_OFS_IN_CSR_L  6'h13
`define AMD_OFS_OUT_MAX_H 6'h14
`define AMD_OFS_OUT_MAX_L 6'h15
`define AMD_OFS_OUT_CSR_H 6'h16
`define AMD_OFS_OUT_CSR_L 6'h17
`define AMD_OFS_OUT_CNT_H 6'h18
`define AMD_OFS_OUT_CNT_L 6'h19
`define AMD_OFS_EP0_FIFO  6'h21
`define AMD_OFS_EP1_FIFO  6'h23
`define AMD_OFS_EP2_FIFO  6'h25
`define AMD_OFS_PA_DATA   6'h26
`define AMD_OFS_PA_DIR    6'h27
`define AMD_OFS_PA_OPT    6'h28
`define AMD_OFS_PB_DATA   6'h29
`define AMD_OFS_PB_DIR    6'h2a
`define AMD_OFS_PB_OPT    6'h2b

`define AMD_RST_PWR       8'h20
`define AMD_RST_IN_IEN    8'h07
`define AMD_RST_OUT_IEN   8'h06
`define AMD_RST_BUS_IEN   8'h06
`define AMD_RST_ZERO      8'h00

`endif

// ---- inc/amd_map_if.sv ----
`timescale 1ns/1ps
interface amd_map_if;
	import amd_pkg::*;
	logic [15:0] addr;
	logic        vec_remap;
	logic        load_active;
	amd_region_e region;
	logic [15:0] local_addr;
	logic        bank_wr;
	logic [5:0]  bank_idx;
	logic [7:0]  bank_wdata;
	amd_bank_t   bank_q;
	modport dec  (input addr, vec_remap, load_active, output region, local_addr);
	modport bank (input bank_wr, bank_idx, bank_wdata, output bank_q);
	modport top  (output addr, vec_remap, load_active, bank_wr, bank_idx, bank_wdata,
		input region, local_addr, bank_q);
endinterface

// ---- inc/amd_pkg.sv ----
package amd_pkg;
	typedef enum logic [3:0] {
		AMD_RG_REG,
		AMD_RG_UNUSED,
		AMD_RG_RSVD,
		AMD_RG_PERIPH,
		AMD_RG_DRAM,
		AMD_RG_CODE,
		AMD_RG_SHARED_DUAL_PORT_RAM,
		AMD_RG_ROM
	} amd_region_e;
	typedef logic [43:0][7:0] amd_bank_t;
endpackage

// ---- rtl/amd_addr_dec.sv ----
`timescale 1ns/1ps
`include "amd_defines.svh"
module amd_addr_dec
	import amd_pkg::*;
(
	amd_map_if.dec m	// Address in, region out
);
	logic [5:0] ofs;

	assign ofs = m.addr[5:0];

	always_comb
	begin
		m.region     = AMD_RG_UNUSED;
		m.local_addr = 16'h0000;
		if (m.addr <= `AMD_REG_LAST)
		begin
			m.local_addr = {10'h000, ofs};
			if (ofs >= `AMD_RSVD_FIRST && ofs <= `AMD_RSVD_LAST)
				m.region = AMD_RG_RSVD;
			else if (ofs == 6'h02 || ofs == 6'h04 || ofs == 6'h06 || ofs == 6'h08
				|| ofs == 6'h20 || ofs == 6'h22 || ofs == 6'h24)
				m.region = AMD_RG_UNUSED;
			else
				m.region = AMD_RG_REG;
		end
		else if (m.addr <= `AMD_PERIPH_LAST)
		begin
			m.region     = AMD_RG_PERIPH;
			m.local_addr = m.addr;
		end
		else if (m.addr >= `AMD_DRAM_BASE && m.addr <= `AMD_DRAM_LAST)
		begin
			m.region     = AMD_RG_DRAM;
			m.local_addr = m.addr - `AMD_DRAM_BASE;
		end
		else if (m.addr >= `AMD_PAGE_BASE && m.addr <= `AMD_PAGE_LAST)
		begin
			m.local_addr = m.addr - `AMD_PAGE_BASE;
			if (!m.load_active)
				m.region = AMD_RG_SHARED_DUAL_PORT_RAM;
			else if (m.local_addr < `AMD_CODE_SIZE)
				m.region = AMD_RG_CODE;
			else
				m.region = AMD_RG_UNUSED;
		end
		else if (m.addr >= `AMD_VEC_BASE && m.vec_remap)
		begin
			m.region     = AMD_RG_DRAM;
			m.local_addr = `AMD_VEC_RAM_BASE + {11'h000, m.addr[4:0]};
		end
		else if (m.addr >= `AMD_ROM_BASE)
		begin
			m.region     = AMD_RG_ROM;
			m.local_addr = m.addr - `AMD_ROM_BASE;
		end
	end
endmodule // amd_addr_dec

// ---- rtl/amd_cpu_map.sv ----
// Function
// - Full 16-bit CPU address decoded
// - Low 44 locations hold hardware registers
// - 4K data RAM, stack 0100h-01FFh
// - 54K read-only program memory mapped
// - Top vectors in ROM, remappable to RAM
// - Coprocessor code RAM and dual-port RAM
// - Both share paged window 1100h-24FFh
// - Load enable set while coprocessor in reset routes window 1100h-18FFh to code RAM
// - Load cleared blocks code RAM access
// - Reserved access resets whole device
// - Unused register holes read 00h
// - IN interrupt enables reset to 07h
`timescale 1ns/1ps
`include "amd_defines.svh"
module amd_cpu_map
	import amd_pkg::*;
(
	input  wire logic        sys_clk,           // 20 MHz clock
	input  wire logic        rst_n,             // Async reset, active low
	input  wire logic [15:0] cpu_addr,          // CPU byte address
	input  wire logic        cpu_rd,            // Read strobe
	input  wire logic        cpu_wr,            // Write strobe
	input  wire logic [7:0]  cpu_wdata,         // Write data
	output logic      [7:0]  cpu_rdata,         // Read data, cycle after
	input  wire logic        vec_remap,         // Vectors taken from RAM
	input  wire logic        code_ram_load_enable, // Load bit of coprocessor control
	input  wire logic        coproc_in_reset,   // Coprocessor held in reset
	output logic             load_active,       // Code RAM currently routed
	output logic             device_reset_req,  // Reserved access, one pulse
	output logic             stack_hit,         // Access in stack area
	output logic             dram_sel,          // Data RAM select
	output logic             code_sel,          // Code RAM select
	output logic             shared_dual_port_ram_sel,         // Dual-port RAM select
	output logic             rom_sel,           // Program ROM select
	output logic             periph_sel,        // Other peripheral select
	output logic             mem_wr,            // Write to selected memory
	output logic      [15:0] mem_addr,          // Local memory address
	output logic      [7:0]  mem_wdata,         // Memory write data
	input  wire logic [7:0]  dram_rdata,        // Data RAM read data
	input  wire logic [7:0]  code_rdata,        // Code RAM read data
	input  wire logic [7:0]  shared_dual_port_ram_rdata,       // Dual-port RAM read data
	input  wire logic [7:0]  rom_rdata,         // ROM read data
	input  wire logic [7:0]  periph_rdata,      // Peripheral read data
	input  wire logic [7:0]  in_endpoint_interrupt_flags,  // USB core status
	input  wire logic [7:0]  out_endpoint_interrupt_flags, // USB core status
	input  wire logic [7:0]  bus_event_interrupt_flags,    // USB core status
	input  wire logic [15:0] frame_number,      // USB frame number
	input  wire logic [15:0] out_byte_count,    // OUT endpoint count
	output logic      [2:0]  fifo_rd,           // Endpoint FIFO read pulses
	output logic      [2:0]  fifo_wr,           // Endpoint FIFO write pulses
	output logic      [7:0]  fifo_wdata,        // Endpoint FIFO write data
	input  wire logic [7:0]  ep0_fifo_rdata,    // Control endpoint data
	input  wire logic [7:0]  ep1_fifo_rdata,    // Endpoint one data
	input  wire logic [7:0]  ep2_fifo_rdata,    // Endpoint two data
	output logic      [7:0]  power_management,  // Register contents
	output logic      [7:0]  function_address,  // Register contents
	output logic      [7:0]  in_interrupt_enables,  // Register contents
	output logic      [7:0]  out_interrupt_enables, // Register contents
	output logic      [7:0]  bus_event_interrupt_enables, // Register contents
	output logic      [7:0]  test_modes,        // Register contents
	output logic      [7:0]  endpoint_index,    // Register contents
	output logic      [7:0]  port_a_out,        // Port A data latch
	output logic      [7:0]  port_a_dir,        // Port A direction
	output logic      [7:0]  port_a_opt,        // Port A options
	output logic      [7:0]  port_b_out,        // Port B data latch
	output logic      [7:0]  port_b_dir,        // Port B direction
	output logic      [7:0]  port_b_opt         // Port B options
);
	typedef struct packed {
		logic        load_armed;
		logic        rst_req;
		logic        rd_q;
		amd_region_e region_q;
		logic [7:0]  reg_q;
		logic [2:0]  fifo_rd;
		logic [2:0]  fifo_wr;
		logic [7:0]  fifo_wdata;
	} amd_state_s;

	amd_state_s st;
	amd_state_s next_st;

	amd_map_if m ();

	logic        access;
	logic [5:0]  idx;
	logic [7:0]  reg_rd;
	logic        reg_writable;
	logic [15:0] laddr;
	amd_region_e region;

	assign m.addr        = cpu_addr;
	assign m.vec_remap   = vec_remap;
	assign m.load_active = st.load_armed;

	amd_addr_dec u_dec (
		.m (m)
	);

	amd_reg_bank u_bank (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.b       (m)
	);

	assign region = m.region;
	assign laddr  = m.local_addr;
	assign idx    = laddr[5:0];
	assign access = cpu_rd || cpu_wr;

	always_comb
	begin
		unique case (idx)
			`AMD_OFS_PWR, `AMD_OFS_FUNCTION_ADDRESS, `AMD_OFS_IN_IEN, `AMD_OFS_OUT_IEN,
			`AMD_OFS_BUS_IEN, `AMD_OFS_TEST, `AMD_OFS_INDEX, `AMD_OFS_IN_MAX_H,
			`AMD_OFS_IN_MAX_L, `AMD_OFS_IN_CSR_H, `AMD_OFS_IN_CSR_L, `AMD_OFS_OUT_MAX_H,
			`AMD_OFS_OUT_MAX_L, `AMD_OFS_OUT_CSR_H, `AMD_OFS_OUT_CSR_L, `AMD_OFS_PA_DATA,
			`AMD_OFS_PA_DIR, `AMD_OFS_PA_OPT, `AMD_OFS_PB_DATA, `AMD_OFS_PB_DIR,
			`AMD_OFS_PB_OPT:
				reg_writable = 1'b1;
			default:
				reg_writable = 1'b0;
		endcase
	end

	assign m.bank_wr    = cpu_wr && region == AMD_RG_REG && reg_writable;
	assign m.bank_idx   = idx;
	assign m.bank_wdata = cpu_wdata;

	// Read value for the register window
	always_comb
	begin
		unique case (idx)
			`AMD_OFS_IN_FLAGS:  reg_rd = in_endpoint_interrupt_flags;
			`AMD_OFS_OUT_FLAGS: reg_rd = out_endpoint_interrupt_flags;
			`AMD_OFS_BUS_FLAGS: reg_rd = bus_event_interrupt_flags;
			`AMD_OFS_FRAME_HI:  reg_rd = frame_number[15:8];
			`AMD_OFS_FRAME_LO:  reg_rd = frame_number[7:0];
			`AMD_OFS_OUT_CNT_H: reg_rd = out_byte_count[15:8];
			`AMD_OFS_OUT_CNT_L: reg_rd = out_byte_count[7:0];
			`AMD_OFS_EP0_FIFO:  reg_rd = ep0_fifo_rdata;
			`AMD_OFS_EP1_FIFO:  reg_rd = ep1_fifo_rdata;
			`AMD_OFS_EP2_FIFO:  reg_rd = ep2_fifo_rdata;
			default:
				if (idx < 6'h2c)
					reg_rd = m.bank_q[idx];
				else
					reg_rd = 8'h00;
		endcase
	end

	always_comb
	begin
		next_st          = st;
		next_st.rst_req  = 1'b0;
		next_st.rd_q     = cpu_rd;
		next_st.fifo_rd  = 3'h0;
		next_st.fifo_wr  = 3'h0;
		if (code_ram_load_enable && coproc_in_reset)
			next_st.load_armed = 1'b1;
		if (!code_ram_load_enable)
			next_st.load_armed = 1'b0;
		if (cpu_rd)
			next_st.region_q = region;
		if (cpu_rd)
			next_st.reg_q = (region == AMD_RG_REG) ? reg_rd : 8'h00;
		if (access && region == AMD_RG_RSVD)
			next_st.rst_req = 1'b1;
		if (access && region == AMD_RG_REG)
		begin
			unique case (idx)
				`AMD_OFS_EP0_FIFO:
				begin
					next_st.fifo_rd[0] = cpu_rd;
					next_st.fifo_wr[0] = cpu_wr;
				end
				`AMD_OFS_EP1_FIFO:
				begin
					next_st.fifo_rd[1] = cpu_rd;
					next_st.fifo_wr[1] = cpu_wr;
				end
				`AMD_OFS_EP2_FIFO:
				begin
					next_st.fifo_rd[2] = cpu_rd;
					next_st.fifo_wr[2] = cpu_wr;
				end
				default:
				begin
				end
			endcase
		end
		if (cpu_wr)
			next_st.fifo_wdata = cpu_wdata;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st.load_armed <= 1'b0;
			st.rst_req    <= 1'b0;
			st.rd_q       <= 1'b0;
			st.region_q   <= AMD_RG_UNUSED;
			st.reg_q      <= 8'h00;
			st.fifo_rd    <= 3'h0;
			st.fifo_wr    <= 3'h0;
			st.fifo_wdata <= 8'h00;
		end
		else
			st <= next_st;
	end

	// Memory selects follow the live decode
	always_comb
	begin
		dram_sel   = 1'b0;
		code_sel   = 1'b0;
		shared_dual_port_ram_sel  = 1'b0;
		rom_sel    = 1'b0;
		periph_sel = 1'b0;
		unique case (region)
			AMD_RG_DRAM:   dram_sel = access;
			AMD_RG_CODE:   code_sel = access;
			AMD_RG_SHARED_DUAL_PORT_RAM:  shared_dual_port_ram_sel = access;
			AMD_RG_ROM:    rom_sel = cpu_rd;
			AMD_RG_PERIPH: periph_sel = access;
			default:
			begin
			end
		endcase
	end

	assign stack_hit = access && cpu_addr >= `AMD_STACK_BASE
		&& cpu_addr <= `AMD_STACK_LAST;

	assign mem_addr  = laddr;
	assign mem_wr    = cpu_wr && region != AMD_RG_ROM;
	assign mem_wdata = cpu_wdata;

	// Memories answer one cycle after the strobe, as the register path does
	always_comb
	begin
		unique case (st.region_q)
			AMD_RG_DRAM:   cpu_rdata = dram_rdata;
			AMD_RG_CODE:   cpu_rdata = code_rdata;
			AMD_RG_SHARED_DUAL_PORT_RAM:  cpu_rdata = shared_dual_port_ram_rdata;
			AMD_RG_ROM:    cpu_rdata = rom_rdata;
			AMD_RG_PERIPH: cpu_rdata = periph_rdata;
			default:       cpu_rdata = st.reg_q;
		endcase
	end

	assign load_active      = st.load_armed;
	assign device_reset_req = st.rst_req;
	assign fifo_rd          = st.fifo_rd;
	assign fifo_wr          = st.fifo_wr;
	assign fifo_wdata       = st.fifo_wdata;

	// register outputs come from bank contents, loaded with reset values
	assign power_management            = m.bank_q[`AMD_OFS_PWR];
	assign function_address            = m.bank_q[`AMD_OFS_FUNCTION_ADDRESS];
	assign in_interrupt_enables        = m.bank_q[`AMD_OFS_IN_IEN];
	assign out_interrupt_enables       = m.bank_q[`AMD_OFS_OUT_IEN];
	assign bus_event_interrupt_enables = m.bank_q[`AMD_OFS_BUS_IEN];
	assign test_modes                  = m.bank_q[`AMD_OFS_TEST];
	assign endpoint_index              = m.bank_q[`AMD_OFS_INDEX];
	assign port_a_out                  = m.bank_q[`AMD_OFS_PA_DATA];
	assign port_a_dir                  = m.bank_q[`AMD_OFS_PA_DIR];
	assign port_a_opt                  = m.bank_q[`AMD_OFS_PA_OPT];
	assign port_b_out                  = m.bank_q[`AMD_OFS_PB_DATA];
	assign port_b_dir                  = m.bank_q[`AMD_OFS_PB_DIR];
	assign port_b_opt                  = m.bank_q[`AMD_OFS_PB_OPT];
endmodule // amd_cpu_map

// ---- rtl/amd_reg_bank.sv ----
`timescale 1ns/1ps
`include "amd_defines.svh"
module amd_reg_bank
	import amd_pkg::*;
(
	input wire logic sys_clk,	// System clock
	input wire logic rst_n,		// Async reset, active low
	amd_map_if.bank  b		// Write port, contents out
);
	typedef struct packed {
		amd_bank_t r;
	} amd_bank_s;

	amd_bank_s st;
	amd_bank_s next_st;
	amd_bank_t next_r;

	function automatic logic [7:0] amd_rst_val(input int i);
		case (i)
			int'(`AMD_OFS_PWR):     return `AMD_RST_PWR;
			int'(`AMD_OFS_IN_IEN):  return `AMD_RST_IN_IEN;
			int'(`AMD_OFS_OUT_IEN): return `AMD_RST_OUT_IEN;
			int'(`AMD_OFS_BUS_IEN): return `AMD_RST_BUS_IEN;
			default:                return `AMD_RST_ZERO;
		endcase
	endfunction

	genvar gi;
	generate
		for (gi = 0; gi < 44; gi++)
		begin : g_byte
			assign next_r[gi] = (b.bank_wr && b.bank_idx == 6'(gi)) ? b.bank_wdata
				: st.r[gi];
		end
	endgenerate

	always_comb
	begin
		next_st   = st;
		next_st.r = next_r;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < 44; i++)
				st.r[i] <= amd_rst_val(i);
		end
		else
			st <= next_st;
	end

	assign b.bank_q = st.r;
endmodule // amd_reg_bank
